// >>> mrtp_mac_model.sv
// Purpose: Behavioural MAC that drives the transmit pins of the port
// Assumes: The bench queues words as {error, enable, data[3:0]}
// Notes:   Idle data lines toggle, all four in MII and the low two in RMII, so a stale value is never valid
`timescale 1ns/1ns
`default_nettype none

module mrtp_mac_model (
	// Clocks and mode
	input  wire logic       clk,
	input  wire logic       rmii,
	input  wire logic       slow,
	input  wire logic       tx_clk_o,
	// MAC transmit pins
	output var logic [3:0]  tx_data_in,
	output var logic        tx_en_in,
	output var logic        tx_err_in,
	output var logic        ref_clk_in
);
	logic [5:0] q[$];           // Words waiting to go out
	logic [2:0] ref_cnt = 3'h0; // Phase of the 160 ns reference clock
	logic [3:0] rep_cnt = 4'h0; // Periods the current dibit has stood

	initial begin
		tx_data_in = 4'h0;
		tx_en_in = 1'b0;
		tx_err_in = 1'b0;
		ref_clk_in = 1'b0;
	end

	// Next word, or idle with enable low and changing data
	task automatic step();
		logic [5:0] w;
		if (q.size() > 0) begin
			w = q.pop_front();
			tx_data_in <= w[3:0];
			tx_en_in <= w[4];
			tx_err_in <= w[5];
		end else begin
			tx_en_in <= 1'b0;
			tx_err_in <= 1'b0;
			// Upper lines stay low in reduced mode
			tx_data_in <= rmii ? {2'h0, ~tx_data_in[1:0]} : ~tx_data_in;
		end
	endtask : step

	// MII: change just after the port's transmit clock rises
	always @(posedge tx_clk_o) begin
		if (!rmii) step();
	end

	// RMII: free reference clock, data changes on its falling edge
	always @(posedge clk) begin
		ref_cnt <= ref_cnt + 3'h1;
		ref_clk_in <= ref_cnt[2];
		if (rmii && ref_cnt == 3'h0) begin
			// At 10 Mb each dibit stands ten periods, so any phase of
			// the port's decimation takes it exactly once
			if (!slow || rep_cnt == 4'h9) begin
				rep_cnt <= 4'h0;
				step();
			end else begin
				rep_cnt <= rep_cnt + 4'h1;
			end
		end
	end
endmodule : mrtp_mac_model
`default_nettype wire

// >>> mrtp_pkg.sv
// Purpose: Shared constants for the MII/RMII transmit port block
// Assumes: 50 MHz system clock, 8-bit register port
// Notes:   Register offsets, field positions, reset values and timing

package mrtp_pkg;

	// Clock rates and transmit clock half periods, in system cycles
	localparam int CLK_HZ        = 50_000_000;
	localparam int TXCLK_100_HZ  = 25_000_000;
	localparam int TXCLK_10_HZ   = 2_500_000;
	localparam int HALF_100      = CLK_HZ / (2 * TXCLK_100_HZ);
	localparam int HALF_10       = CLK_HZ / (2 * TXCLK_10_HZ);
	// RMII at 10 Mb/s repeats each dibit this many reference edges
	localparam int RMII_10_REPEAT = 10;
	// Capture counter value at which the straps are taken, on the third cycle after reset release
	localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2;

	// Register offsets
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK   = 4'h2;
	localparam logic [3:0] ADDR_STATE  = 4'h3;

	// Control fields
	localparam int CTRL_SPEED100 = 0;
	localparam int CTRL_EEE_EN   = 1;
	localparam int CTRL_SYMBOL   = 2;
	localparam logic [7:0] CTRL_RESET = 8'h01;

	// Event bits of status and mask
	localparam int EV_FRAME_START = 0;
	localparam int EV_FRAME_END   = 1;
	localparam int EV_TX_ERROR    = 2;
	localparam int EV_LPI_ENTER   = 3;
	localparam int EV_LPI_EXIT    = 4;
	localparam int EV_UPPER_BITS  = 5;
	localparam int EV_NUM         = 6;
	localparam logic [7:0] MASK_RESET = 8'h00;

	// State fields
	localparam int ST_RMII   = 0;
	localparam int ST_LPI    = 1;
	localparam int ST_ACTIVE = 2;
	localparam int ST_IRQFN  = 3;

	// Transmit Error code-group
	localparam logic [4:0] CODE_H = 5'h04;

	// 4B/5B data code-groups
	function automatic logic [4:0] mrtp_enc(input logic [3:0] nib);
		logic [4:0] c;
		c = 5'h00;
		unique case (nib)
			4'h0: c = 5'h1e;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0a;
			4'h5: c = 5'h0b;
			4'h6: c = 5'h0e;
			4'h7: c = 5'h0f;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'ha: c = 5'h16;
			4'hb: c = 5'h17;
			4'hc: c = 5'h1a;
			4'hd: c = 5'h1b;
			4'he: c = 5'h1c;
			4'hf: c = 5'h1d;
		endcase
		return c;
	endfunction : mrtp_enc

endpackage : mrtp_pkg

// >>> mrtp_tx_port.sv
// Purpose: Transmit side of the MAC interface of a 10/100 PHY
// Assumes: One 50 MHz clock; MAC pins and straps arrive asynchronously
// Notes:   Straps are taken once, three cycles after reset release
// Function
// - Lowest two data lines used in every mode
// - Data bits 2,3 used only in MII
// - Active-low open-drain interrupt, released when idle
// - Error at 100 Mb MII sends /H/
// - Error input ignored at 10 Mb/s
// - EEE: error with enable off means LPI
// - RMII ignores error and symbol bit, no clock
// - Symbol mode: error line is code-group MSB
// - Data valid only while enable is high
// - RMII takes only the two low lines
// - MII: PHY drives and samples with transmit clock
// - Transmit clock 25 MHz or 2.5 MHz
// - Strap low selects MII, high RMII
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module mrtp_tx_port
	import mrtp_pkg::*;
(
	// System clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// MAC transmit pins
	input  wire logic [3:0] tx_data_in,
	input  wire logic       tx_en_in,
	input  wire logic       tx_err_in,
	input  wire logic       ref_clk_in,
	// Configuration straps
	input  wire logic       reduced_iface_select_strap,
	input  wire logic       irq_pin_function_strap,
	// Transmit clock pin
	output logic            tx_clk_o,
	output logic            tx_clk_oe,
	// Interrupt pin, open drain
	output logic            irq_out_low_o,
	output logic            irq_out_low_oe,
	// Encoded stream toward the line side
	output logic [4:0]      sym_o,
	output logic            sym_valid_o,
	output logic            lpi_o,
	// Register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata
);

	// All checks run on the one system clock and rest during reset
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// Synchronisers for all pins: first stage feeds only second
	logic [8:0] pin_meta_reg;    // First stage
	logic [8:0] pin_sync_reg;    // Second stage, safe to read
	logic       ref_d_reg;       // Previous synced reference clock
	logic [3:0] txd_s;           // Synced data lines
	logic       en_s;            // Synced enable
	logic       err_s;           // Synced error line
	logic       symbol_msb_in;   // Same pin as error, symbol mode
	logic       ref_s;           // Synced reference clock

	// Pins sampled into the clock domain before any logic reads them
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta_reg <= 9'h000;
			pin_sync_reg <= 9'h000;
			ref_d_reg    <= 1'b0;
		end else begin
			pin_meta_reg <= {irq_pin_function_strap,
				reduced_iface_select_strap, ref_clk_in, tx_err_in,
				tx_en_in, tx_data_in};
			pin_sync_reg <= pin_meta_reg;
			ref_d_reg    <= pin_sync_reg[6];
		end
	end

	assign txd_s         = pin_sync_reg[3:0];
	assign en_s          = pin_sync_reg[4];
	assign err_s         = pin_sync_reg[5];
	assign symbol_msb_in = pin_sync_reg[5];
	assign ref_s         = pin_sync_reg[6];

	// Straps caught once after reset release
	logic [1:0] cap_cnt_reg;     // Waits for the synchronisers to fill
	logic       rmii_reg;        // High selects the reduced interface
	logic       irq_fn_reg;      // High lets the pin act as interrupt

	// Strap capture once the sync stages hold real pin levels
	always_ff @(posedge clk) begin
		if (srst) begin
			cap_cnt_reg <= 2'h0;
			rmii_reg    <= 1'b0;
			irq_fn_reg  <= 1'b0;
		end else if (cap_cnt_reg != 2'h3) begin
			cap_cnt_reg <= cap_cnt_reg + 2'h1;
			if (cap_cnt_reg == STRAP_CAPTURE_CNT) begin
				rmii_reg   <= pin_sync_reg[7];
				irq_fn_reg <= pin_sync_reg[8];
			end
		end
	end

	// Software control
	logic [7:0] ctrl_reg;        // Speed, EEE and symbol mode
	logic       speed100;
	logic       eee_en;
	logic       symbol_mode;
	assign speed100    = ctrl_reg[CTRL_SPEED100];
	assign eee_en      = ctrl_reg[CTRL_EEE_EN];
	// Symbol mode only makes sense on the 100 Mb MII path
	assign symbol_mode = ctrl_reg[CTRL_SYMBOL] & speed100 & ~rmii_reg;

	// Transmit clock divider; one-cycle enable on each rising edge
	logic [3:0] div_cnt_reg;     // Half period counter
	logic       txclk_reg;       // Clock level driven to the MAC
	logic       txclk_oe_reg;    // Pin driven only in MII
	logic [1:0] rise_pipe_reg;   // Delays the edge to match the sync
	logic [3:0] half_m1;
	assign half_m1 = speed100 ? 4'(HALF_100 - 1) : 4'(HALF_10 - 1);

	always_ff @(posedge clk) begin
		if (srst || rmii_reg) begin
			div_cnt_reg  <= 4'h0;
			txclk_reg    <= 1'b0;
			txclk_oe_reg <= 1'b0;
		end else begin
			txclk_oe_reg <= 1'b1;
			if (div_cnt_reg >= half_m1) begin
				div_cnt_reg <= 4'h0;
				txclk_reg   <= ~txclk_reg;
			end else begin
				div_cnt_reg <= div_cnt_reg + 4'h1;
			end
		end
	end

	a_rmii_no_clk: assert property (rmii_reg |-> ##1 !tx_clk_oe)
		else $error("transmit clock driven in RMII");
	a_fast_clock: assert property (
		!rmii_reg && speed100 && $stable(speed100) && txclk_oe_reg
		|=> tx_clk_o != $past(tx_clk_o))
		else $error("25 MHz clock not toggling");

	// MAC changes just after our rising edge, so data that passed two
	// flops is mid-period stable two cycles after that edge
	always_ff @(posedge clk) begin
		if (srst) begin
			rise_pipe_reg <= 2'h0;
		end else begin
			rise_pipe_reg <= {rise_pipe_reg[0], ~rmii_reg & ~txclk_reg &
				(div_cnt_reg >= half_m1)};
		end
	end

	// Reference clock edges; at 10 Mb only every tenth is taken
	logic [3:0] rep_cnt_reg;
	logic       ref_rise;
	assign ref_rise = ref_s & ~ref_d_reg;

	always_ff @(posedge clk) begin
		if (srst || !rmii_reg || speed100) begin
			rep_cnt_reg <= 4'h0;
		end else if (ref_rise) begin
			if (rep_cnt_reg == 4'(RMII_10_REPEAT - 1))
				rep_cnt_reg <= 4'h0;
			else
				rep_cnt_reg <= rep_cnt_reg + 4'h1;
		end
	end

	logic sample;                // One sampling instant of the MAC pins
	assign sample = rmii_reg ?
		(ref_rise && (speed100 || rep_cnt_reg == 4'h0)) :
		rise_pipe_reg[1];

	// Qualified view of the error line per mode
	logic err_q;
	assign err_q = err_s & ~rmii_reg & speed100;

	// Dibit pairing in RMII: first dibit is the low half of a nibble
	logic       phase_reg;       // High once the low dibit is held
	logic [1:0] low_dibit_reg;
	logic       en_prev_reg;     // Enable at the previous sample

	always_ff @(posedge clk) begin
		if (srst) begin
			phase_reg     <= 1'b0;
			low_dibit_reg <= 2'h0;
			en_prev_reg   <= 1'b0;
		end else if (sample) begin
			en_prev_reg <= en_s;
			if (rmii_reg && en_s) begin
				phase_reg     <= ~phase_reg;
				low_dibit_reg <= txd_s[1:0];
			end else begin
				phase_reg <= 1'b0;                 // Realign each frame
			end
		end
	end

	// Nibble assembled for this sample, and whether one is complete
	logic [3:0] nib;
	logic       nib_ready;
	assign nib       = rmii_reg ? {txd_s[1:0], low_dibit_reg} :
		txd_s;
	assign nib_ready = sample && en_s && (!rmii_reg || phase_reg);

	// Low dibit then high dibit; 10 Mb spacing stays inside the range
	sequence s_two_dibits;
		(sample && en_s && rmii_reg && !phase_reg) ##[1:100]
		(sample && en_s && phase_reg);
	endsequence

	a_dibit_pair: assert property (s_two_dibits |=> sym_valid_o)
		else $error("dibits not paired");

	// Code-group out: 10 Mb nibble, symbol bypass, error substitution or 4B/5B
	logic [4:0] code;
	always_comb begin
		if (!speed100 || rmii_reg && !speed100)
			code = {1'b0, nib};                    // Nibble at 10 Mb
		else if (symbol_mode)
			code = {symbol_msb_in, nib};
		else if (err_q)
			code = CODE_H;
		else
			code = mrtp_enc(nib);
	end

	logic [4:0] sym_reg;
	logic       sym_valid_reg;
	logic       lpi_reg;
	logic       lpi_next;
	// LPI needs EEE, 100 Mb MII and no symbol bypass
	assign lpi_next = eee_en & ~en_s & err_q & ~symbol_mode;

	// Stream outputs; data outside the enable window never passes
	always_ff @(posedge clk) begin
		if (srst) begin
			sym_reg       <= 5'h00;
			sym_valid_reg <= 1'b0;
			lpi_reg       <= 1'b0;
		end else begin
			sym_valid_reg <= nib_ready;
			if (nib_ready)
				sym_reg <= code;
			if (sample)
				lpi_reg <= lpi_next;
		end
	end

	sequence s_err_sample;
		sample && en_s && err_q && !symbol_mode && !rmii_reg;
	endsequence

	a_err_gives_h: assert property (s_err_sample |=>
		sym_valid_o && sym_o == CODE_H)
		else $error("error did not give /H/");
	a_ten_err_off: assert property (!speed100 && nib_ready |=>
		sym_o[4] == 1'b0)
		else $error("error seen at 10 Mb");
	a_lpi_request: assert property (sample && lpi_next |=> lpi_o)
		else $error("LPI request lost");
	a_symbol_msb: assert property (nib_ready && symbol_mode |=>
		sym_o == {$past(err_s), $past(txd_s)})
		else $error("symbol MSB wrong");
	a_valid_window: assert property (sym_valid_o |->
		$past(en_s) && $past(sample))
		else $error("valid outside enable");

	// Events raised at sampling instants
	logic [EV_NUM-1:0] ev;
	always_comb begin
		ev = '0;
		ev[EV_FRAME_START] = sample & en_s & ~en_prev_reg;
		ev[EV_FRAME_END]   = sample & ~en_s & en_prev_reg;
		ev[EV_TX_ERROR]    = sample & en_s & err_q & ~symbol_mode;
		ev[EV_LPI_ENTER]   = sample & lpi_next & ~lpi_reg;
		ev[EV_LPI_EXIT]    = sample & ~lpi_next & lpi_reg;
		// MAC broke the grounding of the upper lines
		ev[EV_UPPER_BITS]  = sample & rmii_reg &
			(txd_s[3:2] != 2'h0);
	end

	// Register file
	logic [7:0] status_reg;      // Sticky events, cleared by reading
	logic [7:0] mask_reg;        // Enables events onto the interrupt
	logic       rd_status;
	assign rd_status = reg_rd && reg_addr == ADDR_STATUS;

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_reg <= CTRL_RESET;
			mask_reg <= MASK_RESET;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_CTRL)
				ctrl_reg <= reg_wdata;
			if (reg_addr == ADDR_MASK)
				mask_reg <= reg_wdata;
		end
	end

	// A set in the clearing cycle survives the read
	always_ff @(posedge clk) begin
		if (srst)
			status_reg <= 8'h00;
		else
			status_reg <= (rd_status ? 8'h00 : status_reg) |
				{{(8 - EV_NUM){1'b0}}, ev};
	end

	// Read data in the cycle after the strobe; unmapped reads zero
	logic [7:0] rdata_reg;
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CTRL:   rdata_reg <= ctrl_reg;
				ADDR_STATUS: rdata_reg <= status_reg;
				ADDR_MASK:   rdata_reg <= mask_reg;
				ADDR_STATE:  rdata_reg <= {4'h0, irq_fn_reg,
					en_prev_reg, lpi_reg, rmii_reg};
				default:     rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// Interrupt pin: pulled low only while something is pending
	logic irq_oe_reg;
	logic irq_low_reg;           // Open drain only ever drives low
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_oe_reg  <= 1'b0;
			irq_low_reg <= 1'b0;
		end else begin
			irq_low_reg <= 1'b0;
			irq_oe_reg  <= irq_fn_reg && |(status_reg & mask_reg);
		end
	end

	a_irq_release: assert property (
		(status_reg & mask_reg) == 8'h00 |=> !irq_out_low_oe)
		else $error("interrupt held with nothing pending");

	assign tx_clk_o       = txclk_reg;
	assign tx_clk_oe      = txclk_oe_reg;
	assign irq_out_low_o  = irq_low_reg;
	assign irq_out_low_oe = irq_oe_reg;
	assign sym_o          = sym_reg;
	assign sym_valid_o    = sym_valid_reg;
	assign lpi_o          = lpi_reg;
	assign reg_rdata      = rdata_reg;


endmodule : mrtp_tx_port

`default_nettype wire

// >>> mrtp_tx_port_bench.sv
// Purpose: Self-checking bench of the transmit port
// Assumes: 50 MHz clock, MAC model on the pins, register port tasks
// Notes:   Each scenario is its own task and judges its own results
`timescale 1ns/1ns
`default_nettype none

module mrtp_tx_port_bench import mrtp_pkg::*;;
	// Clock, reset, straps
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       rmii_strap = 1'b0;
	logic       irq_strap = 1'b1;
	logic       mac_slow = 1'b0;   // MAC repeats dibits for 10 Mb RMII
	// Register port
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	// Pins and line side
	logic [3:0] tx_data_in;
	logic       tx_en_in, tx_err_in, ref_clk_in, tx_clk_o, tx_clk_oe;
	logic       irq_out_low_o, irq_out_low_oe, sym_valid_o, lpi_o;
	logic [4:0] sym_o;
	// Open-drain pin with its pull-up
	wire logic  irq_pin = irq_out_low_oe ? irq_out_low_o : 1'b1;
	// Bookkeeping
	int         failures = 0;
	int         checks_done = 0;
	int         cycles = 0;
	logic [7:0] rv;
	logic [4:0] got[$];

	mrtp_tx_port dut (.clk, .srst, .tx_data_in, .tx_en_in, .tx_err_in,
		.ref_clk_in, .reduced_iface_select_strap(rmii_strap),
		.irq_pin_function_strap(irq_strap), .tx_clk_o, .tx_clk_oe,
		.irq_out_low_o, .irq_out_low_oe, .sym_o, .sym_valid_o, .lpi_o,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

	mrtp_mac_model mac (.clk, .rmii(rmii_strap), .slow(mac_slow),
		.tx_clk_o, .tx_data_in, .tx_en_in, .tx_err_in, .ref_clk_in);

	always #10 clk = ~clk;

	// Hang guard, far above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic chk(input string n, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask : rchk

	// Queue words, then compare every valid pulse seen in the window
	task automatic send(input int nw, input logic [23:0] w, input int ns,
			input logic [19:0] e, input int cyc);
		for (int i = 0; i < nw; i++) mac.q.push_back(w[6*i +: 6]);
		got.delete();
		repeat (cyc) begin
			@(posedge clk);
			#1;
			if (sym_valid_o === 1'b1) got.push_back(sym_o);
		end
		chk("symbol count", 8'(ns), 8'(got.size()));
		for (int i = 0; i < ns && i < got.size(); i++)
			chk("symbol", {3'h0, e[5*i +: 5]}, {3'h0, got[i]});
	endtask : send

	// Spacing of transmit clock rises, in system cycles
	task automatic per(input int e);
		time t;
		@(posedge tx_clk_o);
		t = $time;
		@(posedge tx_clk_o);
		chk("tx clock cycles", 8'(e), 8'(($time - t) / 20));
	endtask : per

	task automatic do_reset(input logic s);
		srst <= 1'b1;
		rmii_strap <= s;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : do_reset

	task automatic t_regs();
		rchk("control", ADDR_CTRL, CTRL_RESET);
		rchk("mask", ADDR_MASK, MASK_RESET);
		rchk("state", ADDR_STATE, 8'h08);
		wr(4'hc, 8'hff);
		rchk("unmapped", 4'hc, 8'h00);
		chk("clock drive", 8'h01, {7'h0, tx_clk_oe});
		chk("irq pin", 8'h01, {7'h0, irq_pin});
		$display("test registers done");
	endtask : t_regs

	// 100 Mb MII: encoded nibbles, error word becomes /H/
	task automatic t_mii100();
		per(CLK_HZ / TXCLK_100_HZ);
		rchk("status clear", ADDR_STATUS, 8'h00);
		send(4, {6'h30, 6'h1f, 6'h15, 6'h10}, 4,
			{CODE_H, 5'h1d, 5'h0b, 5'h1e}, 60);
		chk("masked irq pin", 8'h01, {7'h0, irq_pin});
		rchk("status", ADDR_STATUS, 8'h07);
		$display("test mii100 done");
	endtask : t_mii100

	// Interrupt raised by an unmasked event, released by the read
	task automatic t_irq();
		wr(ADDR_MASK, 8'h01);
		rchk("mask", ADDR_MASK, 8'h01);
		send(1, 24'h12, 1, 20'h14, 30);
		chk("irq pin low", 8'h00, {7'h0, irq_pin});
		rchk("status", ADDR_STATUS, 8'h03);
		repeat (2) @(posedge clk);
		#1 chk("irq released", 8'h01, {7'h0, irq_pin});
		$display("test irq done");
	endtask : t_irq

	// 10 Mb MII: slow clock, error ignored
	task automatic t_mii10();
		wr(ADDR_CTRL, 8'h00);
		per(CLK_HZ / TXCLK_10_HZ);
		rchk("status clear", ADDR_STATUS, 8'h00);
		send(2, {6'h3a, 6'h33}, 2, {5'h0a, 5'h03}, 200);
		rchk("status", ADDR_STATUS, 8'h03);
		$display("test mii10 done");
	endtask : t_mii10

	// Symbol mode: error line is the code-group MSB
	task automatic t_sym();
		wr(ADDR_CTRL, 8'h05);
		send(2, {6'h1c, 6'h33}, 2, {5'h0c, 5'h13}, 40);
		$display("test symbol done");
	endtask : t_sym

	// EEE: error with enable low asks for low-power idle
	task automatic t_eee();
		wr(ADDR_CTRL, 8'h03);
		rchk("status clear", ADDR_STATUS, 8'h03);
		send(4, {4{6'h20}}, 0, 20'h0, 4);
		send(4, {4{6'h20}}, 0, 20'h0, 4);
		chk("lpi on", 8'h01, {7'h0, lpi_o});
		send(0, 24'h0, 0, 20'h0, 20);
		chk("lpi off", 8'h00, {7'h0, lpi_o});
		rchk("status", ADDR_STATUS, 8'h18);
		send(1, 24'h37, 1, {15'h0, CODE_H}, 20);
		$display("test eee done");
	endtask : t_eee

	// RMII: dibits, upper lines and error ignored, no clock driven
	task automatic t_rmii();
		@(posedge clk);
		do_reset(1'b1);
		rchk("state", ADDR_STATE, 8'h09);
		chk("clock drive", 8'h00, {7'h0, tx_clk_oe});
		rchk("status clear", ADDR_STATUS, 8'h00);
		send(4, {6'h3e, 6'h3d, 6'h31, 6'h32}, 2,
			{5'h13, 5'h0e}, 80);
		rchk("status", ADDR_STATUS, 8'h23);
		$display("test rmii done");
	endtask : t_rmii

	// RMII at 10 Mb with the interrupt strap off: pin stays released
	task automatic t_rmii10();
		@(posedge clk);
		irq_strap <= 1'b0;
		do_reset(1'b1);
		rchk("state", ADDR_STATE, 8'h01);
		wr(ADDR_MASK, 8'hff);
		wr(ADDR_CTRL, 8'h00);
		mac_slow <= 1'b1;
		send(2, 24'h000491, 1, 20'h00009, 400);
		chk("irq pin off", 8'h01, {7'h0, irq_pin});
		rchk("status", ADDR_STATUS, 8'h03);
		$display("test rmii10 done");
	endtask : t_rmii10

	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		do_reset(1'b0);
		t_regs();
		t_mii100();
		t_irq();
		t_mii10();
		t_sym();
		t_eee();
		t_rmii();
		t_rmii10();
		wrap_up();
	end
endmodule : mrtp_tx_port_bench
`default_nettype wire
